// ===== core/pmx_pkg.sv
/*
 * Constants for the power-mode and external interrupt configuration block.
 * Assumes an 8-bit special function register port from the CPU core and a
 * CPU sequencer that reports instruction completion.
 */
package pmx_pkg;
  localparam logic [7:0] PMX_ADDR_PWR  = 8'h87;
  localparam logic [7:0] PMX_ADDR_EXT  = 8'he4;
  localparam logic [7:0] PMX_ADDR_VPRI = 8'hf7;
  localparam logic [7:0] PMX_ADDR_VEN  = 8'he7;
  localparam logic [7:0] PMX_RST_PWR   = 8'h00;
  localparam logic [7:0] PMX_RST_EXT   = 8'h01;
  localparam logic [7:0] PMX_RST_VPRI  = 8'h00;
  localparam logic [7:0] PMX_RST_VEN   = 8'h00;
  localparam int PMX_IDLE_BIT = 0;
  localparam int PMX_STOP_BIT = 1;
  localparam int PMX_FLAG_LO  = 2;
  localparam int PMX_FLAG_HI  = 7;
  localparam int PMX_A_POL    = 3;
  localparam int PMX_B_POL    = 7;
  localparam int PMX_A_SEL_LO = 0;
  localparam int PMX_B_SEL_LO = 4;
  localparam int PMX_SEL_W    = 3;
  localparam int PMX_MCD_TIMEOUT_US = 100;
  localparam int PMX_CLK_MHZ  = 100;
  localparam int PMX_MCD_CYC  = PMX_MCD_TIMEOUT_US * PMX_CLK_MHZ;
  typedef enum logic [2:0] {
    PMX_RUN  = 3'b001,
    PMX_IDLE = 3'b010,
    PMX_STOP = 3'b100
  } pmx_state_t;
endpackage

// ===== core/pmx_irq_if.sv
/*
 * Carrier between the top and the external interrupt pin selector.
 * Assumes port 0 is sampled synchronously to sys_clk.
 */
`timescale 1ns/1ps
interface pmx_irq_if;
  logic [7:0] port0;
  logic [2:0] sel;
  logic       pol;
  logic       active;
  modport top (output port0, output sel, output pol, input active);
  modport sel_side (input port0, input sel, input pol, output active);
endinterface

// ===== core/pmx_pin_sel.sv
/*
 * Picks one port 0 pin and applies the polarity for one external interrupt.
 * Assumes pin levels are synchronous; it only reads them.
 */
`timescale 1ns/1ps
module pmx_pin_sel (
  // Clock and reset
  input wire logic    sys_clk,
  input wire logic    srst,
  // Selection
  pmx_irq_if.sel_side irq
);
  import pmx_pkg::*;

  // Registered so the request is a clean flop output
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq.active <= 1'b0;
    end else begin
      irq.active <= irq.port0[irq.sel] ^ ~irq.pol;
    end
  end
endmodule

// ===== core/pmx_vbus_gate.sv
/*
 * Gates the VBUS level interrupt and splits it into priority levels.
 * Assumes the CPU interrupt logic arbitrates the two outputs.
 */
`timescale 1ns/1ps
module pmx_vbus_gate (
  // Inputs
  input wire logic  vbus_req,
  input wire logic  enable,
  input wire logic  priority_hi,
  // Outputs
  output logic      req_hi,
  output logic      req_lo
);
  assign req_hi = vbus_req & enable & priority_hi;
  assign req_lo = vbus_req & enable & ~priority_hi;
endmodule

// ===== core/pmx_top.sv
/*
 * Power-mode control, VBUS interrupt enable/priority and external interrupt
 * pin routing. Registers sit on the CPU's special function register port.
 * Assumes the CPU asserts insn_done at the end of each instruction and that
 * reset sources (watchdog, missing clock detector, pin) feed srst.
 */
`timescale 1ns/1ps
module pmx_top
  import pmx_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic [7:0]      sfr_rdata,
  // CPU sequencer
  input  wire logic       insn_done,
  input  wire logic       irq_pending,
  output logic            cpu_halt,
  output logic            digital_stop,
  output logic            int_osc_stop,
  output pmx_pkg::pmx_state_t pwr_state,
  // Interrupt sources
  input  wire logic [7:0] port0_pins,
  input  wire logic       vbus_level_req,
  output logic            ext_irq_a,
  output logic            ext_irq_b,
  output logic            vbus_irq_hi,
  output logic            vbus_irq_lo,
  // Watchdog and suspend
  input  wire logic       watchdog_enabled,
  output logic            watchdog_run,
  input  wire logic       osc_suspend_req,
  input  wire logic       usb_event,
  input  wire logic       vbus_level,
  input  wire logic       vbus_wake_polarity,
  output logic            osc_suspended
);
  import pmx_pkg::*;

  // ********************************
  // Registers
  // ********************************
  logic [5:0] scratch_flags;
  logic [7:0] ext_cfg;
  logic       vbus_irq_priority;
  logic       vbus_irq_enable;
  logic       idle_req;
  logic       stop_req;
  pmx_state_t state;
  pmx_state_t next_state;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scratch_flags <= PMX_RST_PWR[PMX_FLAG_HI:PMX_FLAG_LO];
    end else if (sfr_wr && hit(sfr_addr, PMX_ADDR_PWR)) begin
      scratch_flags <= sfr_wdata[PMX_FLAG_HI:PMX_FLAG_LO];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ext_cfg <= PMX_RST_EXT;
    end else if (sfr_wr && hit(sfr_addr, PMX_ADDR_EXT)) begin
      ext_cfg <= sfr_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      vbus_irq_priority <= PMX_RST_VPRI[0];
      vbus_irq_enable   <= PMX_RST_VEN[0];
    end else begin
      if (sfr_wr && hit(sfr_addr, PMX_ADDR_VPRI)) begin
        vbus_irq_priority <= sfr_wdata[0];
      end
      if (sfr_wr && hit(sfr_addr, PMX_ADDR_VEN)) begin
        vbus_irq_enable <= sfr_wdata[0];
      end
    end
  end

  // ********************************
  // Mode requests
  // ********************************
  // Requests wait for the writing instruction to finish before acting
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      idle_req <= 1'b0;
      stop_req <= 1'b0;
    end else if (sfr_wr && hit(sfr_addr, PMX_ADDR_PWR)) begin
      stop_req <= sfr_wdata[PMX_STOP_BIT];
      idle_req <= sfr_wdata[PMX_IDLE_BIT] & ~sfr_wdata[PMX_STOP_BIT];
    end else if (insn_done) begin
      idle_req <= 1'b0;
      stop_req <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      PMX_RUN: begin
        if (insn_done && stop_req) begin
          next_state = PMX_STOP;
        end else if (insn_done && idle_req) begin
          next_state = PMX_IDLE;
        end
      end
      PMX_IDLE: begin
        if (irq_pending) begin
          next_state = PMX_RUN;
        end
      end
      PMX_STOP: begin
        next_state = PMX_STOP;
      end
      default: next_state = PMX_RUN;
    endcase
  end

  // Reset leaves any mode; the CPU restarts at its reset vector
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= PMX_RUN;
    end else begin
      state <= next_state;
    end
  end

  assign pwr_state    = state;
  assign cpu_halt     = (state != PMX_RUN);
  assign digital_stop = (state == PMX_STOP);
  assign watchdog_run = watchdog_enabled && (state != PMX_STOP);

  // ********************************
  // Oscillator suspend
  // ********************************
  logic suspended;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      suspended <= 1'b0;
    end else if (usb_event || (vbus_level == vbus_wake_polarity)) begin
      suspended <= 1'b0;
    end else if (osc_suspend_req) begin
      suspended <= 1'b1;
    end
  end
  assign osc_suspended = suspended;
  assign int_osc_stop  = suspended || (state == PMX_STOP);

  // ********************************
  // Interrupt routing
  // ********************************
  pmx_irq_if irq_a ();
  pmx_irq_if irq_b ();
  assign irq_a.port0 = port0_pins;
  assign irq_a.sel   = ext_cfg[PMX_A_SEL_LO +: PMX_SEL_W];
  assign irq_a.pol   = ext_cfg[PMX_A_POL];
  assign irq_b.port0 = port0_pins;
  assign irq_b.sel   = ext_cfg[PMX_B_SEL_LO +: PMX_SEL_W];
  assign irq_b.pol   = ext_cfg[PMX_B_POL];

  pmx_pin_sel u_sel_a (
    .sys_clk (sys_clk),
    .srst    (srst),
    .irq     (irq_a)
  );
  pmx_pin_sel u_sel_b (
    .sys_clk (sys_clk),
    .srst    (srst),
    .irq     (irq_b)
  );
  assign ext_irq_a = irq_a.active;
  assign ext_irq_b = irq_b.active;

  pmx_vbus_gate u_vbus (
    .vbus_req    (vbus_level_req),
    .enable      (vbus_irq_enable),
    .priority_hi (vbus_irq_priority),
    .req_hi      (vbus_irq_hi),
    .req_lo      (vbus_irq_lo)
  );

  // ********************************
  // Read back
  // ********************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        PMX_ADDR_PWR:  sfr_rdata <= {scratch_flags, 2'b00};
        PMX_ADDR_EXT:  sfr_rdata <= ext_cfg;
        PMX_ADDR_VPRI: sfr_rdata <= {7'h00, vbus_irq_priority};
        PMX_ADDR_VEN:  sfr_rdata <= {7'h00, vbus_irq_enable};
        default:       sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ********************************
  // Checks
  // ********************************
  vbus_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
    !vbus_irq_enable |-> !(vbus_irq_hi || vbus_irq_lo)) else $error("vbus passed while disabled");
  vbus_prio_a: assert property (@(posedge sys_clk) disable iff (srst)
    (vbus_level_req && vbus_irq_enable && vbus_irq_priority) |-> vbus_irq_hi && !vbus_irq_lo)
    else $error("vbus priority wrong");
  vpri_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    (sfr_rd && sfr_addr == PMX_ADDR_VPRI) |=> sfr_rdata[7:1] == 7'h00) else $error("vbus prio upper bits");
  ext_a_pin_a: assert property (@(posedge sys_clk) disable iff (srst)
    $stable(ext_cfg) |=> ext_irq_a == $past(port0_pins[ext_cfg[PMX_A_SEL_LO +: PMX_SEL_W]] ~^ ext_cfg[PMX_A_POL]))
    else $error("ext a routing");
  ext_b_pin_a: assert property (@(posedge sys_clk) disable iff (srst)
    $stable(ext_cfg) |=> ext_irq_b == $past(port0_pins[ext_cfg[PMX_B_SEL_LO +: PMX_SEL_W]] ~^ ext_cfg[PMX_B_POL]))
    else $error("ext b routing");
  idle_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == PMX_IDLE && irq_pending) |=> state == PMX_RUN && !cpu_halt) else $error("idle no wake");
  stop_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    state == PMX_STOP |=> state == PMX_STOP && int_osc_stop) else $error("stop left");
  mode_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    (sfr_rd && sfr_addr == PMX_ADDR_PWR) |=> sfr_rdata[1:0] == 2'b00) else $error("mode bits read");
  both_stop_a: assert property (@(posedge sys_clk) disable iff (srst)
    (sfr_wr && sfr_addr == PMX_ADDR_PWR && sfr_wdata[1:0] == 2'b11 && state == PMX_RUN) ##1 insn_done
    |=> state == PMX_STOP) else $error("stop not preferred");
  wdt_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == PMX_IDLE && watchdog_enabled) |-> watchdog_run) else $error("watchdog halted");
endmodule

// ===== verif/pmx_cpu_model.sv
/*
 * Behavioural model of the CPU sequencer and interrupt logic on the far side.
 * Assumes the bench gates instruction flow and interrupt enables.
 */
`timescale 1ns/1ps
module pmx_cpu_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Bench control
  input  wire logic       run_en,
  input  wire logic       irq_en,
  input  wire logic [3:0] gap,
  // Block side
  input  wire logic       cpu_halt,
  input  wire logic       ext_irq_a,
  input  wire logic       ext_irq_b,
  input  wire logic       vbus_irq_hi,
  input  wire logic       vbus_irq_lo,
  output logic            insn_done = 1'b0,
  output logic            irq_pending = 1'b0
);
  // ****
  // Sequencer
  // ****
  logic [3:0] cnt = 4'h0;

  // Gap sets prompt or slow instruction completion
  always @(negedge sys_clk) begin
    if (srst || !run_en || cpu_halt) begin
      cnt <= 4'h0;
      insn_done <= 1'b0;
    end else begin
      insn_done <= (cnt == gap);
      cnt <= (cnt == gap) ? 4'h0 : cnt + 4'h1;
    end
  end

  // Servicing and return stay inside the CPU
  always @(negedge sys_clk) begin
    irq_pending <= irq_en && (ext_irq_a || ext_irq_b || vbus_irq_hi || vbus_irq_lo);
  end
endmodule

// ===== verif/power_mode_and_ext_irq_config_test.sv
/*
 * Self-checking bench for the power-mode and interrupt configuration block.
 * Assumes pmx_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps
module power_mode_and_ext_irq_config_test;
  import pmx_pkg::*;
  // ****
  // Signals
  // ****
  logic       sys_clk = 1'b0, srst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, port0_pins = 8'hff, sfr_rdata, pat;
  logic       vbus_level_req = 1'b0, watchdog_enabled = 1'b1, osc_suspend_req = 1'b0;
  logic       usb_event = 1'b0, vbus_level = 1'b0, vbus_wake_polarity = 1'b1;
  logic       run_en = 1'b0, irq_en = 1'b0, p;
  logic [3:0] gap = 4'h0;
  logic [2:0] s;
  logic       insn_done, irq_pending, cpu_halt, digital_stop, int_osc_stop, ext_irq_a;
  logic       ext_irq_b, vbus_irq_hi, vbus_irq_lo, watchdog_run, osc_suspended;
  pmx_state_t pwr_state;
  int         bad_count = 0, cmp_count = 0, cyc = 0;

  pmx_top DUT (.*);
  pmx_cpu_model cpu (.*);

  initial forever #5 sys_clk = ~sys_clk;

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask
  task automatic wait_st(input pmx_state_t st);
    for (int i = 0; i < 40 && pwr_state !== st; i++) @(negedge sys_clk);
    chk({5'h0, pwr_state}, {5'h0, st});
  endtask
  task automatic reset_dut();
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Tests need well under 2000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  // ****
  // Tests
  // ****
  initial begin
    reset_dut();
    rdc(PMX_ADDR_PWR, PMX_RST_PWR);
    rdc(PMX_ADDR_EXT, PMX_RST_EXT);
    rdc(PMX_ADDR_VPRI, PMX_RST_VPRI);
    rdc(PMX_ADDR_VEN, PMX_RST_VEN);
    wr(PMX_ADDR_PWR, 8'hfc);
    rdc(PMX_ADDR_PWR, 8'hfc);
    wr(PMX_ADDR_VPRI, 8'hff);
    rdc(PMX_ADDR_VPRI, 8'h01);
    wr(8'h10, 8'hff);
    rdc(8'h10, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      wr(PMX_ADDR_VEN, {7'h0, k[0]});
      wr(PMX_ADDR_VPRI, {7'h0, k[1]});
      vbus_level_req = k[2];
      @(negedge sys_clk);
      chk({6'h0, vbus_irq_hi, vbus_irq_lo}, {6'h0, k[0] & k[1] & k[2], k[0] & ~k[1] & k[2]});
    end
    vbus_level_req = 1'b0;
    $display("test vbus gate done");
    // Every pin, both polarities, low, high and one-hot patterns
    for (int k = 0; k < 48; k++) begin
      s = k[2:0];
      p = k[3];
      pat = (k < 16) ? 8'h00 : (k < 32) ? 8'hff : (8'h01 << s);
      wr(PMX_ADDR_EXT, {~p, ~s, p, s});
      port0_pins = pat;
      repeat (2) @(negedge sys_clk);
      chk({6'h0, ext_irq_b, ext_irq_a}, {6'h0, pat[~s] == ~p, pat[s] == p});
    end
    port0_pins = 8'hff;
    wr(PMX_ADDR_EXT, 8'h01);
    $display("test pin select done");
    wr(PMX_ADDR_VEN, 8'h01);
    wr(PMX_ADDR_VPRI, 8'h00);
    irq_en = 1'b1;
    wr(PMX_ADDR_PWR, 8'ha9);
    run_en = 1'b1;
    wait_st(PMX_IDLE);
    repeat (5) @(negedge sys_clk);
    chk({4'h0, cpu_halt, digital_stop, int_osc_stop, watchdog_run}, 8'h09);
    vbus_level_req = 1'b1;
    wait_st(PMX_RUN);
    vbus_level_req = 1'b0;
    run_en = 1'b0;
    rdc(PMX_ADDR_PWR, 8'ha8);
    wr(PMX_ADDR_PWR, 8'h01);
    run_en = 1'b1;
    wait_st(PMX_IDLE);
    reset_dut();
    run_en = 1'b0;
    wait_st(PMX_RUN);
    rdc(PMX_ADDR_PWR, 8'h00);
    $display("test idle done");
    gap = 4'h5;
    wr(PMX_ADDR_PWR, 8'h03);
    run_en = 1'b1;
    wait_st(PMX_STOP);
    chk({4'h0, cpu_halt, digital_stop, int_osc_stop, watchdog_run}, 8'h0e);
    port0_pins = 8'h00;
    repeat (20) @(negedge sys_clk);
    chk({4'h0, irq_pending, pwr_state}, {4'h0, 1'b1, PMX_STOP});
    reset_dut();
    wait_st(PMX_RUN);
    port0_pins = 8'hff;
    irq_en = 1'b0;
    run_en = 1'b0;
    $display("test stop done");
    // Wake by bus activity first, then by matching level
    for (int k = 0; k < 2; k++) begin
      osc_suspend_req = 1'b1;
      @(negedge sys_clk);
      osc_suspend_req = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk({6'h0, osc_suspended, int_osc_stop}, 8'h03);
      usb_event = !k[0];
      vbus_level = k[0];
      repeat (2) @(negedge sys_clk);
      chk({6'h0, osc_suspended, int_osc_stop}, 8'h00);
      usb_event = 1'b0;
      vbus_level = 1'b0;
    end
    $display("test suspend done");
    close_out();
  end
endmodule
